// ### src/lasrb_pkg.sv
// Constants shared by the loop alarm and setpoint register bank
`default_nettype none
package lasrb_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_L2_ALM_BEHAV  = 8'h4f;
   localparam logic [7:0] IDX_L2_ALM_ROUTE  = 8'h50;
   localparam logic [7:0] IDX_L2_HI_THRESH  = 8'h51;
   localparam logic [7:0] IDX_L2_LO_THRESH  = 8'h52;
   localparam logic [7:0] IDX_L2_DEADBAND   = 8'h53;
   localparam logic [7:0] IDX_L3_TARGET     = 8'h54;
   localparam logic [7:0] IDX_L3_MEASURED   = 8'h55;
   localparam logic [7:0] IDX_L3_DRIVE_PCT  = 8'h56;
   localparam logic [7:0] IDX_L3_TUNE_STATE = 8'h57;
   localparam logic [7:0] IDX_L3_CEILING    = 8'h58;
   localparam logic [7:0] IDX_L3_FLOOR      = 8'h59;
   // Own registers: interrupt status and mask
   localparam logic [7:0] IDX_IRQ_STATUS    = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK      = 8'h71;
   // Alarm behaviour bit positions
   localparam int BIT_LATCH   = 1;
   localparam int BIT_OPEN    = 2;
   localparam int BIT_AUDIBLE = 5;
   localparam int BIT_SHUT    = 6;
   // Limits and codes
   localparam logic [15:0] DEADBAND_MAX    = 16'h7fff;
   localparam logic [15:0] TUNE_OFF        = 16'h0000;
   localparam logic [15:0] TUNE_START      = 16'h0001;
   localparam logic [15:0] TUNE_ACTIVE     = 16'h0002;
   localparam logic [15:0] TUNE_STOP       = 16'h0004;
   localparam logic [15:0] RESET_VALUE     = 16'h0000;
   localparam int          NUM_EVENTS      = 15;
   // Interrupt status bits
   localparam int IRQ_ALARM_SET = 0;
   localparam int IRQ_ALARM_CLR = 1;
   localparam int IRQ_TUNE_REQ  = 2;
   localparam int IRQ_BITS      = 3;
   typedef enum logic [2:0] {
      LASRB_ST_OFF    = 3'b001,
      LASRB_ST_ACTIVE = 3'b010,
      LASRB_ST_LATCH  = 3'b100
   } lasrb_alarm_st_t;
endpackage
`default_nettype wire

// ### src/lasrb_alarm_if.sv
// Alarm evaluation signals passed between the bank and its alarm core
`default_nettype none
interface lasrb_alarm_if;
   logic [15:0] behaviour;
   logic        condition;
   logic        ack;
   logic        active;
   modport bank (output behaviour, output condition, output ack,
                 input active);
   modport core (input behaviour, input condition, input ack,
                 output active);
endinterface
`default_nettype wire

// ### src/lasrb_alarm_core.sv
// Loop 2 alarm state machine: self clearing or latching
`default_nettype none
module lasrb_alarm_core
   import lasrb_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   lasrb_alarm_if.core  alm
);
   import lasrb_pkg::*;

   lasrb_alarm_st_t state_q;

   // Latching follows behaviour bit 1; acknowledge only frees an ended alarm
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= LASRB_ST_OFF;
      end else begin
         case (state_q)
            LASRB_ST_OFF: begin
               if (alm.condition) begin
                  state_q <= LASRB_ST_ACTIVE;
               end
            end
            LASRB_ST_ACTIVE: begin
               if (!alm.condition) begin
                  state_q <= alm.behaviour[BIT_LATCH] ? LASRB_ST_LATCH
                                                      : LASRB_ST_OFF;
               end
            end
            LASRB_ST_LATCH: begin
               if (alm.condition) begin
                  state_q <= LASRB_ST_ACTIVE;
               end else if (alm.ack || !alm.behaviour[BIT_LATCH]) begin
                  state_q <= LASRB_ST_OFF;
               end
            end
            default: state_q <= LASRB_ST_OFF;
         endcase
      end
   end

   assign alm.active = (state_q != LASRB_ST_OFF);

   property p_self_clear;
      @(posedge clk) disable iff (rst)
      (!alm.condition && !alm.behaviour[BIT_LATCH] && !alm.active)
         |=> !alm.active;
   endproperty
   a_self_clear: assert property (p_self_clear)
      else $error("alarm rose without condition");

   property p_latch_hold;
      @(posedge clk) disable iff (rst)
      (alm.active && alm.behaviour[BIT_LATCH] && !alm.ack)
         |=> alm.active;
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched alarm dropped without acknowledge");
endmodule
`default_nettype wire

// ### src/lasrb_bank.sv
// AHB-Lite register bank for loop 2 alarms and loop 3 setpoints
//
// The AHB-Lite register port was chosen for this implementation.
`default_nettype none
module lasrb_bank
   import lasrb_pkg::*;
#(
   parameter int EVENTS = 15
)
(
   input  wire logic                MCLK,
   input  wire logic                SYS_RST,
   input  wire logic                HSEL,
   input  wire logic [31:0]         HADDR,
   input  wire logic [1:0]          HTRANS,
   input  wire logic                HWRITE,
   input  wire logic [2:0]          HSIZE,
   input  wire logic [31:0]         HWDATA,
   input  wire logic                HREADY,
   output logic [31:0]              HRDATA,
   output logic                     HREADYOUT,
   output logic                     HRESP,
   input  wire logic signed [15:0]  L2_PROCESS,
   input  wire logic signed [15:0]  L3_PROCESS,
   input  wire logic signed [15:0]  L3_DRIVE,
   input  wire logic                L3_TUNE_BUSY,
   input  wire logic                L3_TUNE_DONE,
   output logic                     L3_TUNE_START,
   output logic                     L3_TUNE_STOP,
   output logic signed [15:0]       L3_SETPOINT,
   output logic [14:0]              EVENT_OUT,
   output logic                     AUDIBLE_ALARM,
   output logic                     CHAMBER_SHUTDOWN,
   output logic                     ALARM_ACTIVE,
   output logic                     IRQ
);
   import lasrb_pkg::*;

   // Routing word carries exactly one bit per event output
   if (EVENTS != NUM_EVENTS) begin : g_bad_events
      $error("EVENTS must equal the fixed event output count");
   end


   // Registers
   logic [15:0]        behav_q;
   logic [14:0]        route_q;
   logic signed [15:0] hi_q;
   logic signed [15:0] lo_q;
   logic [15:0]        deadband_q;
   logic signed [15:0] target_q;
   logic signed [15:0] ceiling_q;
   logic signed [15:0] floor_q;
   logic [15:0]        tune_q;
   logic [IRQ_BITS-1:0] irq_stat_q;
   logic [IRQ_BITS-1:0] irq_mask_q;
   // Captured address phase, then alarm history and latched acknowledge
   logic               wr_pend_q;
   logic [7:0]         wr_idx_q;
   logic               alarm_d1_q;
   logic               ack_q;

   lasrb_alarm_if alm ();

   // Word index from a byte address; upper bits must be zero
   function automatic logic [7:0] word_index(input logic [31:0] a);
      return a[9:2];
   endfunction

   function automatic logic is_mapped(input logic [31:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[31:10] == 22'h0) && (a[1:0] == 2'b00) &&
             ((i >= IDX_L2_ALM_BEHAV && i <= IDX_L3_FLOOR) ||
              i == IDX_IRQ_STATUS || i == IDX_IRQ_MASK);
   endfunction

   logic phase_ok;
   assign phase_ok = HSEL && HREADY && HTRANS[1];

   // Zero wait states, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // Write address phase capture; data lands one cycle later
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
      end else begin
         wr_pend_q <= phase_ok && HWRITE && is_mapped(HADDR);
         wr_idx_q  <= word_index(HADDR);
      end
   end

   logic wr_now;
   assign wr_now = wr_pend_q;

   // Host writable settings; reads of read-only words other than the interrupt status word have no side effect
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         behav_q    <= RESET_VALUE;
         route_q    <= 15'h0000;
         hi_q       <= RESET_VALUE;
         lo_q       <= RESET_VALUE;
         deadband_q <= RESET_VALUE;
         target_q   <= RESET_VALUE;
         ceiling_q  <= RESET_VALUE;
         floor_q    <= RESET_VALUE;
      end else if (wr_now) begin
         case (wr_idx_q)
            IDX_L2_ALM_BEHAV: behav_q <= HWDATA[15:0];
            IDX_L2_ALM_ROUTE: route_q <= HWDATA[14:0];
            IDX_L2_HI_THRESH: hi_q <= HWDATA[15:0];
            IDX_L2_LO_THRESH: lo_q <= HWDATA[15:0];
            IDX_L2_DEADBAND: begin
               // Sign bit dropped so the value stays non-negative
               deadband_q <= HWDATA[15:0] & DEADBAND_MAX;
            end
            IDX_L3_TARGET:  target_q  <= HWDATA[15:0];
            IDX_L3_CEILING: ceiling_q <= HWDATA[15:0];
            IDX_L3_FLOOR:   floor_q   <= HWDATA[15:0];
            default: ;
         endcase
      end
   end

   // Autotune word: host requests, hardware reports progress
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         tune_q <= TUNE_OFF;
      end else if (wr_now && wr_idx_q == IDX_L3_TUNE_STATE &&
                   (HWDATA[15:0] == TUNE_START ||
                    HWDATA[15:0] == TUNE_STOP ||
                    HWDATA[15:0] == TUNE_OFF)) begin
         tune_q <= HWDATA[15:0];
      end else if (L3_TUNE_BUSY) begin
         tune_q <= TUNE_ACTIVE;
      end else if (L3_TUNE_DONE) begin
         tune_q <= TUNE_OFF;
      end
   end

   // Request pulses to the tuner, one per host request
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         L3_TUNE_START <= 1'b0;
         L3_TUNE_STOP  <= 1'b0;
      end else begin
         L3_TUNE_START <= wr_now && wr_idx_q == IDX_L3_TUNE_STATE &&
                          HWDATA[15:0] == TUNE_START;
         L3_TUNE_STOP  <= wr_now && wr_idx_q == IDX_L3_TUNE_STATE &&
                          HWDATA[15:0] == TUNE_STOP;
      end
   end

   // Setpoint clamped into its limits before leaving the bank
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         L3_SETPOINT <= RESET_VALUE;
      end else if (target_q > ceiling_q) begin
         L3_SETPOINT <= ceiling_q;
      end else if (target_q < floor_q) begin
         L3_SETPOINT <= floor_q;
      end else begin
         L3_SETPOINT <= target_q;
      end
   end

   // Loop 2 process alarm with deadband on the way out
   logic signed [16:0] hi_rel;
   logic signed [16:0] lo_rel;
   logic               cond;
   always_comb begin
      hi_rel = 17'(hi_q) - 17'(signed'({1'b0, deadband_q}));
      lo_rel = 17'(lo_q) + 17'(signed'({1'b0, deadband_q}));
      if (alm.active) begin
         cond = (17'(L2_PROCESS) > hi_rel) || (17'(L2_PROCESS) < lo_rel);
      end else begin
         cond = (L2_PROCESS > hi_q) || (L2_PROCESS < lo_q);
      end
   end

   // Only the listed behaviour bits reach the core
   assign alm.behaviour = behav_q & ((16'h1 << BIT_LATCH) |
                          (16'h1 << BIT_OPEN) | (16'h1 << BIT_AUDIBLE) |
                          (16'h1 << BIT_SHUT));
   assign alm.condition = cond;
   assign alm.ack       = ack_q;

   lasrb_alarm_core u_core (
      .clk (MCLK),
      .rst (SYS_RST),
      .alm (alm.core)
   );

   // Alarm consequences, registered
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         EVENT_OUT        <= 15'h0000;
         AUDIBLE_ALARM    <= 1'b0;
         CHAMBER_SHUTDOWN <= 1'b0;
         ALARM_ACTIVE     <= 1'b0;
      end else begin
         ALARM_ACTIVE     <= alm.active;
         // Open on alarm drives routed outputs high when quiet
         EVENT_OUT <= route_q & {15{alm.active ^
                      alm.behaviour[BIT_OPEN]}};
         AUDIBLE_ALARM    <= alm.active &&
                             alm.behaviour[BIT_AUDIBLE];
         CHAMBER_SHUTDOWN <= alm.active &&
                             alm.behaviour[BIT_SHUT];
      end
   end

   // Read data: registered in address phase, valid in data phase
   logic        rd_read;
   logic [15:0] rd_word;
   always_comb begin
      rd_word = 16'h0000;
      case (word_index(HADDR))
         IDX_L2_ALM_BEHAV:  rd_word = behav_q;
         IDX_L2_ALM_ROUTE:  rd_word = {1'b0, route_q};
         IDX_L2_HI_THRESH:  rd_word = hi_q;
         IDX_L2_LO_THRESH:  rd_word = lo_q;
         IDX_L2_DEADBAND:   rd_word = deadband_q;
         IDX_L3_TARGET:     rd_word = target_q;
         IDX_L3_MEASURED:   rd_word = L3_PROCESS;
         IDX_L3_DRIVE_PCT:  rd_word = L3_DRIVE;
         IDX_L3_TUNE_STATE: rd_word = tune_q;
         IDX_L3_CEILING:    rd_word = ceiling_q;
         IDX_L3_FLOOR:      rd_word = floor_q;
         IDX_IRQ_STATUS:    rd_word = {13'h0, irq_stat_q};
         IDX_IRQ_MASK:      rd_word = {13'h0, irq_mask_q};
         default:           rd_word = 16'h0000;
      endcase
   end
   assign rd_read = phase_ok && !HWRITE && is_mapped(HADDR);

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_read) begin
         HRDATA <= {16'h0000, rd_word};
      end
   end

   // Reading the status word also acknowledges a latched alarm
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= rd_read && word_index(HADDR) == IDX_IRQ_STATUS;
      end
   end

   // Sticky events; a new event wins over the read clear
   logic [IRQ_BITS-1:0] irq_ev;
   assign irq_ev = {L3_TUNE_START, alarm_d1_q && !alm.active,
                    !alarm_d1_q && alm.active};
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_stat_q <= '0;
         alarm_d1_q <= 1'b0;
      end else begin
         alarm_d1_q <= alm.active;
         if (rd_read && word_index(HADDR) == IDX_IRQ_STATUS) begin
            irq_stat_q <= irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_mask_q <= '0;
      end else if (wr_now && wr_idx_q == IDX_IRQ_MASK) begin
         irq_mask_q <= HWDATA[IRQ_BITS-1:0];
      end
   end

   assign IRQ = |(irq_stat_q & irq_mask_q);

   property p_shutdown;
      @(posedge MCLK) disable iff (SYS_RST)
      alm.active && behav_q[BIT_SHUT] |=> CHAMBER_SHUTDOWN;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("chamber not shut down on alarm");

   property p_audible;
      @(posedge MCLK) disable iff (SYS_RST)
      !behav_q[BIT_AUDIBLE] |=> !AUDIBLE_ALARM;
   endproperty
   a_audible: assert property (p_audible)
      else $error("audible alarm without enable");

   property p_open_action;
      @(posedge MCLK) disable iff (SYS_RST)
      alm.active && behav_q[BIT_OPEN] |=> EVENT_OUT == 15'h0000;
   endproperty
   a_open_action: assert property (p_open_action)
      else $error("open on alarm output still closed");

   property p_route;
      @(posedge MCLK) disable iff (SYS_RST)
      alm.active && !behav_q[BIT_OPEN] |=> EVENT_OUT == $past(route_q);
   endproperty
   a_route: assert property (p_route)
      else $error("event outputs do not follow routing");

   property p_deadband;
      @(posedge MCLK) disable iff (SYS_RST)
      1'b1 |-> !deadband_q[15];
   endproperty
   a_deadband: assert property (p_deadband)
      else $error("deadband went negative");

   sequence s_tune_wr;
      wr_now && wr_idx_q == IDX_L3_TUNE_STATE && HWDATA[15:0] == TUNE_START;
   endsequence
   property p_tune_start;
      @(posedge MCLK) disable iff (SYS_RST)
      s_tune_wr |=> L3_TUNE_START ##1 !L3_TUNE_START;
   endproperty
   a_tune_start: assert property (p_tune_start)
      else $error("tune start pulse wrong");

   property p_sp_limit;
      @(posedge MCLK) disable iff (SYS_RST)
      ##1 (floor_q <= ceiling_q) && $stable(floor_q) && $stable(ceiling_q)
         |-> L3_SETPOINT <= ceiling_q;
   endproperty
   a_sp_limit: assert property (p_sp_limit)
      else $error("setpoint above ceiling");

   property p_ignored_bits;
      @(posedge MCLK) disable iff (SYS_RST)
      alm.behaviour[0] == 1'b0 && alm.behaviour[4:3] == 2'b00 &&
         alm.behaviour[15:7] == 9'h0;
   endproperty
   a_ignored_bits: assert property (p_ignored_bits)
      else $error("unlisted behaviour bit reached the core");
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the loop alarm and setpoint register bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lasrb_pkg::*;

   logic               mclk, sys_rst, hsel, hwrite, hready;
   logic [31:0]        haddr, hwdata, hrdata;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic               hreadyout, hresp, busy, done, t_start, t_stop;
   logic signed [15:0] l2_pv, l3_pv, l3_drv, setpoint;
   logic [14:0]        event_out;
   logic               audible, shut, alarm, irq;
   int                 fails, checks, n_start, n_stop;
   logic [31:0]        rd, pat;
   logic [15:0]        m;

   // The one slave's ready is the bus's ready
   assign hready = hreadyout;

   lasrb_bank #(.EVENTS(15)) dut (
      .MCLK(mclk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .L2_PROCESS(l2_pv), .L3_PROCESS(l3_pv),
      .L3_DRIVE(l3_drv), .L3_TUNE_BUSY(busy), .L3_TUNE_DONE(done),
      .L3_TUNE_START(t_start), .L3_TUNE_STOP(t_stop),
      .L3_SETPOINT(setpoint), .EVENT_OUT(event_out),
      .AUDIBLE_ALARM(audible), .CHAMBER_SHUTDOWN(shut),
      .ALARM_ACTIVE(alarm), .IRQ(irq));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Pulses are counted per cycle, so a stretched pulse shows as extra
   always @(posedge mclk) begin
      if (t_start === 1'b1) n_start++;
      if (t_stop === 1'b1) n_stop++;
   end

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One AHB single transfer; every wait is on ready, never a cycle count
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= w;
      hsize  <= 3'b010;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
      if (hresp !== 1'b0) chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, idx, d, dummy);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, idx, 32'h0, r);
      chk(r, exp);
   endtask

   // Bounded wait for the alarm level, then let derived outputs settle
   task automatic wait_alarm(input logic lvl);
      int n;
      n = 0;
      while (alarm !== lvl && n < 12) begin
         @(posedge mclk);
         n++;
      end
      repeat (2) @(posedge mclk);
      chk({31'h0, alarm}, {31'h0, lvl});
   endtask

   // Watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      conclude();
   end

   initial begin
      sys_rst = 1'b1; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; busy = 1'b0;
      done = 1'b0; l2_pv = 16'sh0000; l3_pv = 16'shfb2e;
      l3_drv = 16'shd8f0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk({12'h0, event_out, audible, shut, alarm, irq, hreadyout}, 32'h1);
      // Reset values, with the read-only inputs showing through
      for (int i = 8'h4f; i <= 8'h59; i++) begin
         if (i == 8'h55) rchk(i[7:0], 32'h0000_fb2e);
         else if (i == 8'h56) rchk(i[7:0], 32'h0000_d8f0);
         else rchk(i[7:0], 32'h0);
      end
      rchk(IDX_IRQ_STATUS, 32'h0);
      rchk(IDX_IRQ_MASK, 32'h0);
      // Full-width patterns; read-only places must not take them
      for (int i = 8'h4f; i <= 8'h59; i++)
         if (i != 8'h57) wr(i[7:0], {16'hdead, i[7:0] | 8'h80, i[7:0]});
      for (int i = 8'h4f; i <= 8'h59; i++) begin
         pat = {16'h0, i[7:0] | 8'h80, i[7:0]};
         if (i == 8'h55) rchk(i[7:0], 32'h0000_fb2e);
         else if (i == 8'h56) rchk(i[7:0], 32'h0000_d8f0);
         // Routing keeps 15 outputs, deadband drops its sign bit
         else if (i == 8'h53 || i == 8'h50)
            rchk(i[7:0], pat & 32'h7fff);
         else if (i != 8'h57) rchk(i[7:0], pat);
      end
      // Unmapped place: write dropped, read repeats the last data
      wr(8'h60, 32'h1234);
      rchk(IDX_L3_FLOOR, 32'h0000_d959);
      rchk(8'h60, 32'h0000_d959);
      // Setpoint follows the target within the limits
      wr(IDX_L3_CEILING, 32'h01f4);
      wr(IDX_L3_FLOOR, 32'hff38);
      wr(IDX_L3_TARGET, 32'h0320);
      repeat (2) @(posedge mclk);
      chk({16'h0, setpoint}, 32'h01f4);
      wr(IDX_L3_TARGET, 32'hfed4);
      repeat (2) @(posedge mclk);
      chk({16'h0, setpoint}, 32'hff38);
      wr(IDX_L3_TARGET, 32'h007b);
      repeat (2) @(posedge mclk);
      chk({16'h0, setpoint}, 32'h007b);
      // Alarm band 10.0 .. -10.0 with a deadband of 1.0
      wr(IDX_L2_ALM_BEHAV, 32'h0);
      wr(IDX_L2_HI_THRESH, 32'h0064);
      wr(IDX_L2_LO_THRESH, 32'hff9c);
      wr(IDX_L2_DEADBAND, 32'h000a);
      wr(IDX_IRQ_MASK, 32'h7);
      wait_alarm(1'b0);
      xfer(1'b0, IDX_IRQ_STATUS, 32'h0, rd);
      // Modes with and without the junk bits, routing on and off
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? 16'hff99 : (k == 1) ? 16'h0064 : 16'h0020;
         pat = (k == 2) ? 32'h0 : 32'hc001;
         wr(IDX_L2_ALM_BEHAV, {16'h0, m});
         wr(IDX_L2_ALM_ROUTE, pat);
         l2_pv <= (k == 1) ? -16'sd150 : 16'sd150;
         wait_alarm(1'b1);
         chk({31'h0, audible}, {31'h0, m[5]});
         chk({31'h0, shut}, {31'h0, m[6]});
         chk({17'h0, event_out}, {17'h0, pat[14:0] & {15{~m[2]}}});
         chk({31'h0, irq}, 32'h1);
         rchk(IDX_IRQ_STATUS, 32'h1);
         chk({31'h0, irq}, 32'h0);
         l2_pv <= (k == 1) ? -16'sd95 : 16'sd95;
         repeat (6) @(posedge mclk);
         chk({31'h0, alarm}, 32'h1);
         l2_pv <= 16'sd0;
         wait_alarm(1'b0);
         chk({17'h0, event_out}, {17'h0, pat[14:0] & {15{m[2]}}});
         chk({30'h0, audible, shut}, 32'h0);
         rchk(IDX_IRQ_STATUS, 32'h2);
      end
      // Latching: holds after the cause ends until status is read
      wr(IDX_L2_ALM_BEHAV, 32'h0002);
      l2_pv <= 16'sd150;
      wait_alarm(1'b1);
      l2_pv <= 16'sd0;
      repeat (8) @(posedge mclk);
      chk({31'h0, alarm}, 32'h1);
      rchk(IDX_IRQ_STATUS, 32'h1);
      wait_alarm(1'b0);
      rchk(IDX_IRQ_STATUS, 32'h2);
      // Masked events set status but leave the interrupt low
      wr(IDX_L2_ALM_BEHAV, 32'h0);
      wr(IDX_IRQ_MASK, 32'h0);
      l2_pv <= 16'sd150;
      wait_alarm(1'b1);
      chk({31'h0, irq}, 32'h0);
      l2_pv <= 16'sd0;
      wait_alarm(1'b0);
      rchk(IDX_IRQ_STATUS, 32'h3);
      wr(IDX_IRQ_MASK, 32'h7);
      // Tuning codes: start, running, bad code, stop, done, off
      wr(IDX_L3_TUNE_STATE, {16'h0, TUNE_START});
      repeat (2) @(posedge mclk);
      chk(n_start, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rchk(IDX_IRQ_STATUS, 32'h4);
      busy <= 1'b1;
      repeat (2) @(posedge mclk);
      rchk(IDX_L3_TUNE_STATE, {16'h0, TUNE_ACTIVE});
      wr(IDX_L3_TUNE_STATE, 32'h0003);
      rchk(IDX_L3_TUNE_STATE, {16'h0, TUNE_ACTIVE});
      wr(IDX_L3_TUNE_STATE, {16'h0, TUNE_STOP});
      repeat (2) @(posedge mclk);
      chk({n_start[15:0], n_stop[15:0]}, 32'h0001_0001);
      busy <= 1'b0;
      done <= 1'b1;
      @(posedge mclk);
      done <= 1'b0;
      repeat (2) @(posedge mclk);
      rchk(IDX_L3_TUNE_STATE, {16'h0, TUNE_OFF});
      wr(IDX_L3_TUNE_STATE, {16'h0, TUNE_OFF});
      rchk(IDX_L3_TUNE_STATE, {16'h0, TUNE_OFF});
      chk({n_start[15:0], n_stop[15:0]}, 32'h0001_0001);
      conclude();
   end
endmodule
`default_nettype wire
